// ### rpsc_top.sv
// Purpose: Config bank for packet handler and synthesizer, with derived controls
// Assumes: Classic Wishbone slave; all radio-side inputs are on sys_clk
// Notes: Radio-side inputs come from same-clock logic, so they are not synchronised
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module rpsc_top
   import rpsc_pkg::*;
#(
   parameter int ADR_W = 18,
   parameter int SPACING_W = 8,
   parameter int FREQ_W = 24
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Settings held outside this bank
   input wire logic [7:0] packet_length_limit,
   input wire logic [1:0] address_filter_mode,
   input wire logic [FREQ_W-1:0] base_freq_word,
   input wire logic [SPACING_W-1:0] carrier_slot_number_spacing,
   // Radio datapath hooks
   input wire logic rx_active,
   input wire logic tx_active,
   input wire logic tx_bit_strobe,
   input wire logic tx_payload_bit,
   input wire logic rx_addr_valid,
   input wire logic [7:0] rx_addr_byte,
   input wire logic rx_len_valid,
   input wire logic [7:0] rx_len_byte,
   // Configuration and derived controls
   output logic whitening_enable,
   output logic legacy_checksum_mode,
   output logic crc_tx_append,
   output logic crc_rx_check,
   output logic tx_bit,
   output logic [4:0] intermediate_freq_word,
   output logic [FREQ_W-1:0] synth_freq_word,
   output logic addr_pass,
   output logic addr_pass_valid,
   output logic [7:0] pkt_len,
   output logic pkt_len_ok,
   output logic pkt_len_valid
);
   ////////////////////////////////////////////////////////////////////////////
   // Register file
   logic [6:0] pkt_cfg_q;
   logic [6:0] pkt_cfg_d;
   logic [7:0] node_addr_q;
   logic [7:0] node_addr_d;
   logic [7:0] carrier_slot_number_q;
   logic [7:0] carrier_slot_number_d;
   logic [5:0] if_ctrl_q;
   logic [5:0] if_ctrl_d;
   logic [7:0] foffs_q;
   logic [7:0] foffs_d;
   logic ack_q;
   logic ack_d;
   logic [31:0] rdat_q;
   logic [31:0] rdat_d;
   logic [15:0] idx;
   logic req;

   assign idx = 16'(wb_adr_i[ADR_W-1:2]);
   // Ack blocks a retake, so a strobe held through ack is taken once
   assign req = wb_cyc_i && wb_stb_i && !ack_q;

   always_comb begin
      pkt_cfg_d = pkt_cfg_q;
      node_addr_d = node_addr_q;
      carrier_slot_number_d = carrier_slot_number_q;
      if_ctrl_d = if_ctrl_q;
      foffs_d = foffs_q;
      ack_d = req;
      // Read data is zero outside an answered access; a write acks with the register's old value
      rdat_d = 32'h0;
      if (req) begin
         // Unused bits read zero and ignore writes; unmapped reads return zero
         if (idx == RPSC_IDX_PKT_CFG) begin
            rdat_d = {25'h0, pkt_cfg_q};
            if (wb_we_i && wb_sel_i[0]) begin
               pkt_cfg_d = wb_dat_i[6:0] & RPSC_PKT_CFG_WMASK;
            end
         end else if (idx == RPSC_IDX_NODE_ADDR) begin
            rdat_d = {24'h0, node_addr_q};
            if (wb_we_i && wb_sel_i[0]) begin
               node_addr_d = wb_dat_i[7:0];
            end
         end else if (idx == RPSC_IDX_CARRIER_SLOT_NUMBER) begin
            rdat_d = {24'h0, carrier_slot_number_q};
            if (wb_we_i && wb_sel_i[0]) begin
               carrier_slot_number_d = wb_dat_i[7:0];
            end
         end else if (idx == RPSC_IDX_IF_CTRL) begin
            // Reserved bit 5 is kept for read-back only
            rdat_d = {26'h0, if_ctrl_q};
            if (wb_we_i && wb_sel_i[0]) begin
               if_ctrl_d = wb_dat_i[5:0];
            end
         end else if (idx == RPSC_IDX_FOFFS) begin
            rdat_d = {24'h0, foffs_q};
            if (wb_we_i && wb_sel_i[0]) begin
               foffs_d = wb_dat_i[7:0];
            end
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pkt_cfg_q <= RPSC_PKT_CFG_RST;
         node_addr_q <= RPSC_NODE_ADDR_RST;
         carrier_slot_number_q <= RPSC_CARRIER_SLOT_NUMBER_RST;
         if_ctrl_q <= RPSC_IF_CTRL_RST;
         foffs_q <= RPSC_FOFFS_RST;
         ack_q <= 1'b0;
         rdat_q <= 32'h0;
      end else if (clk_en) begin
         pkt_cfg_q <= pkt_cfg_d;
         node_addr_q <= node_addr_d;
         carrier_slot_number_q <= carrier_slot_number_d;
         if_ctrl_q <= if_ctrl_d;
         foffs_q <= foffs_d;
         ack_q <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   ////////////////////////////////////////////////////////////////////////////
   // Field views
   logic [1:0] fmt;
   logic [1:0] len_mode;
   logic [4:0] if_word;
   assign fmt = pkt_cfg_q[RPSC_FMT_LSB +: 2];
   assign len_mode = pkt_cfg_q[RPSC_LEN_LSB +: 2];
   assign if_word = if_ctrl_q[4:0];

   ////////////////////////////////////////////////////////////////////////////
   // Test transmit source
   logic pn_bit;
   logic pn_mode;
   // Random data is a transmit-only substitution; receive ignores the format
   assign pn_mode = (fmt == RPSC_FMT_PN9) && tx_active;

   // Seed reloads while idle so every test packet starts from the same bits
   rpsc_pn9 u_pn9 (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .restart(!tx_active),
      .advance(pn_mode && tx_bit_strobe),
      .pn_bit(pn_bit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Derived controls
   logic whiten_q;
   logic whiten_d;
   logic legacy_q;
   logic legacy_d;
   logic crc_tx_q;
   logic crc_tx_d;
   logic crc_rx_q;
   logic crc_rx_d;
   logic tx_bit_q;
   logic tx_bit_d;
   logic [4:0] ifw_q;
   logic [4:0] ifw_d;
   logic [FREQ_W-1:0] freq_q;
   logic [FREQ_W-1:0] freq_d;
   logic pass_q;
   logic pass_d;
   logic pass_vld_q;
   logic pass_vld_d;
   logic [7:0] len_q;
   logic [7:0] len_d;
   logic len_ok_q;
   logic len_ok_d;
   logic len_vld_q;
   logic len_vld_d;
   logic [SPACING_W+7:0] carrier_slot_number_prod;
   logic [FREQ_W-1:0] offs_ext;
   logic [FREQ_W-1:0] if_ext;
   logic addr_hit;

   assign carrier_slot_number_prod = {{SPACING_W{1'b0}}, carrier_slot_number_q} * {8'h0, carrier_slot_number_spacing};
   // Offset steps are 4x a base step; sign-extended before the shift
   assign offs_ext = FREQ_W'(signed'({{(FREQ_W-8){foffs_q[7]}}, foffs_q})
                     <<< RPSC_OFFS_SHIFT);
   assign if_ext = FREQ_W'({{(FREQ_W-5){1'b0}}, if_word} << RPSC_IF_SHIFT);

   always_comb begin
      addr_hit = 1'b0;
      case (address_filter_mode)
         RPSC_ADF_NONE: addr_hit = 1'b1;
         RPSC_ADF_NODE: addr_hit = (rx_addr_byte == node_addr_q);
         RPSC_ADF_BC0: begin
            addr_hit = (rx_addr_byte == node_addr_q) ||
                       (rx_addr_byte == RPSC_BCAST_LO);
         end
         default: begin
            addr_hit = (rx_addr_byte == node_addr_q) ||
                       (rx_addr_byte == RPSC_BCAST_LO) ||
                       (rx_addr_byte == RPSC_BCAST_HI);
         end
      endcase
   end

   always_comb begin
      // Software keeps whitening and legacy checksum exclusive; passed through as set
      whiten_d = pkt_cfg_q[RPSC_WHITEN_BIT];
      legacy_d = pkt_cfg_q[RPSC_LEGACY_BIT];
      crc_tx_d = pkt_cfg_q[RPSC_CRC_BIT];
      crc_rx_d = pkt_cfg_q[RPSC_CRC_BIT];
      tx_bit_d = pn_mode ? pn_bit : tx_payload_bit;
      ifw_d = if_word;
      // Sum wraps at the word width; software keeps the result in band
      freq_d = base_freq_word + FREQ_W'(carrier_slot_number_prod) + offs_ext;
      if (rx_active) begin
         freq_d = freq_d - if_ext;
      end
      // Filter result holds as a level until the next address byte
      pass_d = pass_q;
      pass_vld_d = 1'b0;
      if (rx_addr_valid) begin
         pass_d = addr_hit;
         pass_vld_d = 1'b1;
      end
      len_d = len_q;
      len_ok_d = len_ok_q;
      len_vld_d = 1'b0;
      // Reserved length codes fall back to fixed handling
      if (len_mode == RPSC_LEN_VAR) begin
         if (rx_len_valid) begin
            len_d = rx_len_byte;
            len_ok_d = (rx_len_byte <= packet_length_limit);
            len_vld_d = 1'b1;
         end
      end else begin
         len_d = packet_length_limit;
         len_ok_d = 1'b1;
         len_vld_d = rx_len_valid;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         whiten_q <= RPSC_PKT_CFG_RST[RPSC_WHITEN_BIT];
         legacy_q <= RPSC_PKT_CFG_RST[RPSC_LEGACY_BIT];
         crc_tx_q <= RPSC_PKT_CFG_RST[RPSC_CRC_BIT];
         crc_rx_q <= RPSC_PKT_CFG_RST[RPSC_CRC_BIT];
         tx_bit_q <= 1'b0;
         ifw_q <= RPSC_IF_CTRL_RST[4:0];
         freq_q <= '0;
         pass_q <= 1'b0;
         pass_vld_q <= 1'b0;
         len_q <= 8'h0;
         len_ok_q <= 1'b0;
         len_vld_q <= 1'b0;
      end else if (clk_en) begin
         whiten_q <= whiten_d;
         legacy_q <= legacy_d;
         crc_tx_q <= crc_tx_d;
         crc_rx_q <= crc_rx_d;
         tx_bit_q <= tx_bit_d;
         ifw_q <= ifw_d;
         freq_q <= freq_d;
         pass_q <= pass_d;
         pass_vld_q <= pass_vld_d;
         len_q <= len_d;
         len_ok_q <= len_ok_d;
         len_vld_q <= len_vld_d;
      end
   end

   assign whitening_enable = whiten_q;
   assign legacy_checksum_mode = legacy_q;
   assign crc_tx_append = crc_tx_q;
   assign crc_rx_check = crc_rx_q;
   assign tx_bit = tx_bit_q;
   assign intermediate_freq_word = ifw_q;
   assign synth_freq_word = freq_q;
   assign addr_pass = pass_q;
   assign addr_pass_valid = pass_vld_q;
   assign pkt_len = len_q;
   assign pkt_len_ok = len_ok_q;
   assign pkt_len_valid = len_vld_q;
endmodule // rpsc_top
`default_nettype wire

// ### rpsc_pkg.sv
// Purpose: Shared constants for the radio packet and synthesizer config bank
// Assumes: Wishbone word addressing, byte address = 4 * register index
// Notes: Functional notes below list the behaviour kept by the bank
`default_nettype none
package rpsc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [15:0] RPSC_IDX_PKT_CFG = 16'hdf04;
   localparam logic [15:0] RPSC_IDX_NODE_ADDR = 16'hdf05;
   localparam logic [15:0] RPSC_IDX_CARRIER_SLOT_NUMBER = 16'hdf06;
   localparam logic [15:0] RPSC_IDX_IF_CTRL = 16'hdf07;
   localparam logic [15:0] RPSC_IDX_FOFFS = 16'hdf08;
   // Packet handling config fields
   localparam int RPSC_WHITEN_BIT = 6;
   localparam int RPSC_FMT_LSB = 4;
   localparam int RPSC_LEGACY_BIT = 3;
   localparam int RPSC_CRC_BIT = 2;
   localparam int RPSC_LEN_LSB = 0;
   localparam logic [6:0] RPSC_PKT_CFG_WMASK = 7'h7f;
   localparam logic [6:0] RPSC_PKT_CFG_RST = 7'h45;
   // Intermediate frequency control fields
   localparam int RPSC_IF_RSVD_BIT = 5;
   localparam logic [5:0] RPSC_IF_CTRL_RST = 6'h0f;
   localparam logic [7:0] RPSC_NODE_ADDR_RST = 8'h00;
   localparam logic [7:0] RPSC_CARRIER_SLOT_NUMBER_RST = 8'h00;
   localparam logic [7:0] RPSC_FOFFS_RST = 8'h00;
   // Codes
   localparam logic [1:0] RPSC_FMT_NORMAL = 2'h0;
   localparam logic [1:0] RPSC_FMT_PN9 = 2'h2;
   localparam logic [1:0] RPSC_LEN_FIXED = 2'h0;
   localparam logic [1:0] RPSC_LEN_VAR = 2'h1;
   localparam logic [1:0] RPSC_ADF_NONE = 2'h0;
   localparam logic [1:0] RPSC_ADF_NODE = 2'h1;
   localparam logic [1:0] RPSC_ADF_BC0 = 2'h2;
   localparam logic [1:0] RPSC_ADF_BC0FF = 2'h3;
   localparam logic [7:0] RPSC_BCAST_LO = 8'h00;
   localparam logic [7:0] RPSC_BCAST_HI = 8'hff;
   // Frequency word scaling: base in fref/2^16 steps
   localparam int RPSC_BASE_STEP_EXP = 16;
   localparam int RPSC_IF_STEP_EXP = 10;
   localparam int RPSC_OFFS_STEP_EXP = 14;
   localparam int RPSC_IF_SHIFT = RPSC_BASE_STEP_EXP - RPSC_IF_STEP_EXP;
   localparam int RPSC_OFFS_SHIFT = RPSC_BASE_STEP_EXP - RPSC_OFFS_STEP_EXP;
   // PN9 generator seed
   localparam logic [8:0] RPSC_PN9_SEED = 9'h1ff;
endpackage
`default_nettype wire

// ### rpsc_pn9.sv
// Purpose: PN9 pseudo-random bit source for test transmission
// Assumes: Polynomial x^9 + x^5 + 1, one bit per advance strobe
// Notes: Reloads the seed on restart so each test packet starts alike
`timescale 1ns/1ps
`default_nettype none
module rpsc_pn9
   import rpsc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic restart,
   input wire logic advance,
   output logic pn_bit
);
   logic [8:0] lfsr_q;
   logic [8:0] lfsr_d;

   always_comb begin
      lfsr_d = lfsr_q;
      if (restart) begin
         lfsr_d = RPSC_PN9_SEED;
      end else if (advance) begin
         lfsr_d = {lfsr_q[0] ^ lfsr_q[5], lfsr_q[8:1]};
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lfsr_q <= RPSC_PN9_SEED;
      end else if (clk_en) begin
         lfsr_q <= lfsr_d;
      end
   end

   assign pn_bit = lfsr_q[0];
endmodule // rpsc_pn9
`default_nettype wire

// ### rpsc_top_asserts.sv
// Purpose: Port-level checks for the radio config bank
// Assumes: One clock; reset asynchronous, active high
// Notes: Checks abort while clk_en is low, since the bank freezes then
`timescale 1ns/1ps
`default_nettype none
module rpsc_asserts
   import rpsc_pkg::*;
#(
   parameter int ADR_W = 18
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [1:0] address_filter_mode,
   input wire logic tx_active,
   input wire logic tx_payload_bit,
   input wire logic rx_addr_valid,
   input wire logic [7:0] rx_addr_byte,
   input wire logic rx_len_valid,
   input wire logic whitening_enable,
   input wire logic legacy_checksum_mode,
   input wire logic crc_tx_append,
   input wire logic crc_rx_check,
   input wire logic tx_bit,
   input wire logic [4:0] intermediate_freq_word,
   input wire logic addr_pass,
   input wire logic addr_pass_valid,
   input wire logic pkt_len_valid
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst || !clk_en);
   logic take;
   logic wr_cfg;
   logic wr_if;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
   assign wr_cfg = take && wb_we_i && wb_sel_i[0] && wb_adr_i[ADR_W-1:2] == RPSC_IDX_PKT_CFG;
   assign wr_if = take && wb_we_i && wb_sel_i[0] && wb_adr_i[ADR_W-1:2] == RPSC_IDX_IF_CTRL;
   ////////////////////////////////////////
   property p_ack; take |=> wb_ack_o ##1 !wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack not a one-cycle pulse");
   property p_rd_hi; wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0; endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("upper read bits not zero");
   property p_whiten; wr_cfg |=> ##1 whitening_enable == $past(wb_dat_i[6], 2); endproperty
   a_whiten: assert property (p_whiten) else $error("whitening output wrong");
   property p_legacy; wr_cfg |=> ##1 legacy_checksum_mode == $past(wb_dat_i[3], 2); endproperty
   a_legacy: assert property (p_legacy) else $error("legacy checksum output wrong");
   property p_crc;
      wr_cfg |=> ##1 crc_tx_append == $past(wb_dat_i[2], 2) && crc_rx_check == crc_tx_append;
   endproperty
   a_crc: assert property (p_crc) else $error("checksum enables wrong");
   property p_if; wr_if |=> ##1 intermediate_freq_word == $past(wb_dat_i[4:0], 2); endproperty
   a_if: assert property (p_if) else $error("IF word wrong");
   property p_filt; rx_addr_valid && address_filter_mode == 2'h0 |=> addr_pass_valid && addr_pass;
   endproperty
   a_filt: assert property (p_filt) else $error("unfiltered packet dropped");
   property p_bcast;
      rx_addr_valid && address_filter_mode == 2'h3 && (rx_addr_byte == 8'h00
      || rx_addr_byte == 8'hff) |=> addr_pass_valid && addr_pass;
   endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast dropped");
   property p_len; rx_len_valid |=> pkt_len_valid; endproperty
   a_len: assert property (p_len) else $error("length result missing");
   property p_tx; !tx_active |=> tx_bit == $past(tx_payload_bit); endproperty
   a_tx: assert property (p_tx) else $error("idle tx bit not payload");
endmodule // rpsc_asserts
bind rpsc_top rpsc_asserts #(.ADR_W(ADR_W)) chk_u (.*);
`default_nettype wire

// ### testbench.sv
// Purpose: Self-checking bench for the radio config bank
// Assumes: Output checks sample 1 ns after the clock edge; register reads take wb_dat_o at the ack edge
// Notes: Expected values come from field layouts, not from the bank
`timescale 1ns/1ps
`default_nettype none
module testbench
   import rpsc_pkg::*;
;
   logic sys_clk, sys_rst, clk_en, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [17:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [7:0] packet_length_limit, carrier_slot_number_spacing, rx_addr_byte, rx_len_byte, pkt_len;
   logic [1:0] address_filter_mode;
   logic [23:0] base_freq_word, synth_freq_word, e;
   logic rx_active, tx_active, tx_bit_strobe, tx_payload_bit, rx_addr_valid, rx_len_valid;
   logic whitening_enable, legacy_checksum_mode, crc_tx_append, crc_rx_check, tx_bit;
   logic [4:0] intermediate_freq_word;
   logic addr_pass, addr_pass_valid, pkt_len_ok, pkt_len_valid;
   logic [8:0] m;
   logic [7:0] rv [5] = '{8'h45, 8'h00, 8'h00, 8'h0f, 8'h00};
   int fails = 0;
   int comparisons = 0;
   rpsc_top dut_u (.*);
   ////////////////////////////////////////
   task automatic close_out;
      if (fails == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, x, s);
      end
   endtask
   // Waits for ack with no cycle count assumed; the watchdog ends a hang
   task automatic wbx(input logic w, input logic [15:0] i, input logic [7:0] d, input logic [3:0] s);
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= {i, 2'b00};
      wb_sel_i <= s;
      wb_dat_i <= {24'h0, d};
      @(posedge sys_clk);
      while (wb_ack_o !== 1'b1) @(posedge sys_clk);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] i, input logic [7:0] d);
      wbx(1'b1, i, d, 4'h1);
   endtask
   task automatic rdc(input logic [15:0] i, input logic [7:0] x);
      wbx(1'b0, i, 8'h00, 4'h1);
      chk("reg", q, {24'h0, x});
   endtask
   task automatic try_addr(input logic [1:0] md, input logic [7:0] b, input logic x);
      @(posedge sys_clk);
      address_filter_mode <= md;
      rx_addr_valid <= 1'b1;
      rx_addr_byte <= b;
      @(posedge sys_clk);
      rx_addr_valid <= 1'b0;
      #1;
      chk("addr_pass", {addr_pass_valid, addr_pass}, {1'b1, x});
   endtask
   task automatic try_len(input logic [7:0] b, input logic [7:0] xl, input logic xo);
      @(posedge sys_clk);
      rx_len_valid <= 1'b1;
      rx_len_byte <= b;
      @(posedge sys_clk);
      rx_len_valid <= 1'b0;
      #1;
      chk("len", {pkt_len_valid, pkt_len_ok, pkt_len}, {1'b1, xo, xl});
   endtask
   ////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (4000) @(posedge sys_clk);
      fails++;
      close_out;
   end
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, address_filter_mode} = '0;
      {rx_active, tx_active, tx_bit_strobe, tx_payload_bit, rx_addr_valid, rx_len_valid} = '0;
      {rx_addr_byte, rx_len_byte} = '0;
      sys_rst = 1'b1;
      clk_en = 1'b1;
      packet_length_limit = 8'h20;
      base_freq_word = 24'h100000;
      carrier_slot_number_spacing = 8'h10;
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("cfg_out", {whitening_enable, legacy_checksum_mode}, 2'h2);
      chk("crc", {crc_tx_append, crc_rx_check}, 2'h3);
      chk("if", intermediate_freq_word, 5'h0f);
      for (int k = 0; k < 5; k++) rdc(RPSC_IDX_PKT_CFG + 16'(k), rv[k]);
      try_len(8'h20, 8'h20, 1'b1);
      try_len(8'h21, 8'h21, 1'b0);
      // Legacy checksum only with whitening off
      wr(RPSC_IDX_PKT_CFG, 8'h08);
      #1;
      chk("legacy", {whitening_enable, legacy_checksum_mode}, 2'h1);
      chk("crc", {crc_tx_append, crc_rx_check}, 2'h0);
      try_len(8'h33, 8'h20, 1'b1);
      wr(RPSC_IDX_PKT_CFG, 8'h85);
      rdc(RPSC_IDX_PKT_CFG, 8'h05);
      wbx(1'b1, RPSC_IDX_PKT_CFG, 8'h00, 4'h0);
      rdc(RPSC_IDX_PKT_CFG, 8'h05);
      wr(16'hdf09, 8'h55);
      rdc(16'hdf09, 8'h00);
      wr(RPSC_IDX_IF_CTRL, 8'hff);
      rdc(RPSC_IDX_IF_CTRL, 8'h3f);
      chk("if", intermediate_freq_word, 5'h1f);
      wr(RPSC_IDX_CARRIER_SLOT_NUMBER, 8'h03);
      wr(RPSC_IDX_FOFFS, 8'hfe);
      #1;
      // Channel 3 at spacing 0x10, offset -2 in steps of four base steps
      e = base_freq_word + 24'h30 - (24'h2 << 2);
      chk("synth", synth_freq_word, e);
      // With the enable low the receive switch must not reach the word
      @(posedge sys_clk);
      clk_en <= 1'b0;
      rx_active <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      chk("synth_frozen", synth_freq_word, e);
      @(posedge sys_clk);
      clk_en <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk("synth_rx", synth_freq_word, e - (24'h1f << 6));
      wr(RPSC_IDX_PKT_CFG, 8'h25);
      wr(RPSC_IDX_NODE_ADDR, 8'h5a);
      for (int md = 0; md < 4; md++) begin
         try_addr(md[1:0], 8'h5a, 1'b1);
         try_addr(md[1:0], 8'h00, md != 1);
         try_addr(md[1:0], 8'hff, md == 0 || md == 3);
         try_addr(md[1:0], 8'h11, md == 0);
      end
      @(posedge sys_clk);
      rx_active <= 1'b0;
      tx_active <= 1'b1;
      tx_bit_strobe <= 1'b1;
      m = 9'h1ff;
      repeat (20) begin
         @(posedge sys_clk);
         #1;
         chk("pn9", tx_bit, m[0]);
         m = {m[0] ^ m[5], m[8:1]};
      end
      wr(RPSC_IDX_PKT_CFG, 8'h05);
      @(posedge sys_clk);
      tx_payload_bit <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk("tx_bit", tx_bit, 1'b1);
      close_out;
   end
endmodule // testbench
`default_nettype wire
